// ---- core/sebs_defs.svh ----
`ifndef SEBS_DEFS_SVH
`define SEBS_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SEBS_CLK_PERIOD_NS 10
`define SEBS_PROG_TIME_NS 5000000

// ----------------------------------------
// Slave address byte layout
// ----------------------------------------
`define SEBS_SA_FIXED_BIT 7
`define SEBS_SA_FIXED_VAL 1'b1
`define SEBS_SA_SEL_HI 6
`define SEBS_SA_SEL_LO 4
`define SEBS_SA_ADR_HI 3
`define SEBS_SA_ADR_LO 1
`define SEBS_SA_RW_BIT 0
`define SEBS_RW_READ 1'b1

// ----------------------------------------
// Bit counting, reset values and FIFO depth
// ----------------------------------------
`define SEBS_BIT_FIRST 3'h0
`define SEBS_BIT_LAST 3'h7
`define SEBS_LINES_RST 2'h3
`define SEBS_PINS_RST 4'h0
`define SEBS_FIFO_DEPTH 32

`endif

// ---- core/sebs_pkg.sv ----
package sebs_pkg;

    // Bus protocol states
    typedef enum logic [3:0] {
        SEBS_IDLE     = 4'b0000,
        SEBS_DEV      = 4'b0001,
        SEBS_DEV_ACK  = 4'b0010,
        SEBS_WADR     = 4'b0011,
        SEBS_WADR_ACK = 4'b0100,
        SEBS_WDAT     = 4'b0101,
        SEBS_WDAT_ACK = 4'b0110,
        SEBS_RDAT     = 4'b0111,
        SEBS_RACK     = 4'b1000,
        SEBS_WAIT     = 4'b1001
    } sebs_state_t;

    // Filtered bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } sebs_lines_t;

    // One array write headed for the programming engine
    typedef struct packed {
        logic [10:0] addr;
        logic [7:0] data;
    } sebs_wr_t;

endpackage

// ---- core/sebs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sebs_defs.svh"

// ----------------------------------------
// Synchroniser with agreement filter
// ----------------------------------------
module sebs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and filtered result
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Three-stage chain from the pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A bit moves only once the last two stages agree, hiding one-cycle glitches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= RST;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    q[i] <= s3_r[i];
                end
            end
        end
    end
endmodule

// ----------------------------------------
// Valid/ready FIFO
// ----------------------------------------
module sebs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // Full and empty come straight from the fill count
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------
// Two-wire memory slave
// ----------------------------------------
module sebs_top
    import sebs_pkg::*;
#(
    parameter int ADDR_W = 11,
    parameter int PAGE_W = 4,
    parameter int PROG_CYCLES = `SEBS_PROG_TIME_NS / `SEBS_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Bus pins
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA,
    output logic O_SDA_OE_N,
    // Straps and protection
    input wire logic I_SELECT_STRAP_LOW,
    input wire logic I_SELECT_STRAP_MID_INVERTED,
    input wire logic I_SELECT_STRAP_HIGH,
    input wire logic I_WRITE_PROTECT,
    // Status
    output logic O_BUSY
);
    localparam int PAGE_N = 1 << PAGE_W;
    localparam int MEM_N = 1 << ADDR_W;
    localparam int PCW = $clog2(PROG_CYCLES + 1);

    sebs_lines_t lines_f;
    sebs_lines_t lines_q;
    logic [3:0] pins_f;
    logic wp_f;
    logic start_ev;
    logic stop_ev;
    logic rise_ev;
    logic fall_ev;

    sebs_state_t state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic byte_done_r;
    logic drive_r;
    logic rw_r;
    logic first_data_r;
    logic mack_r;
    logic [ADDR_W-1:0] addr_r;

    logic [7:0] page_r [PAGE_N];
    logic [PAGE_N-1:0] page_vld_r;
    logic [ADDR_W-PAGE_W-1:0] page_base_r;
    logic dirty_r;

    logic busy_r;
    logic loading_r;
    logic [PAGE_W:0] load_idx_r;
    logic [PCW-1:0] prog_cnt_r;
    logic [7:0] mem_r [MEM_N];

    logic dev_match;
    logic dev_accept;
    logic wdat_take;
    logic wdat_refuse;
    logic rd_load;
    logic [7:0] rd_byte;
    logic commit;

    sebs_wr_t fifo_in;
    logic fifo_in_valid;
    logic fifo_in_ready;
    sebs_wr_t fifo_out;
    logic fifo_out_valid;
    logic fifo_out_ready;

    // ----------------------------------------
    // Input conditioning
    // ----------------------------------------

    sebs_sync #(.W(2), .RST(`SEBS_LINES_RST)) u_line_sync (
        .clk(I_CLK),
        .rst(I_RESET),
        .d({I_SCL, I_SDA}),
        .q(lines_f)
    );

    // straps reset low
    // Straps and protect are static but still come from outside the clock domain
    sebs_sync #(.W(4), .RST(`SEBS_PINS_RST)) u_pin_sync (
        .clk(I_CLK),
        .rst(I_RESET),
        .d({I_SELECT_STRAP_HIGH, I_SELECT_STRAP_MID_INVERTED, I_SELECT_STRAP_LOW,
            I_WRITE_PROTECT}),
        .q(pins_f)
    );
    assign wp_f = pins_f[0];

    // Previous filtered lines for edge finding
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            lines_q <= `SEBS_LINES_RST;
        end else begin
            lines_q <= lines_f;
        end
    end

    assign start_ev = lines_q.scl && lines_f.scl && lines_q.sda && !lines_f.sda;
    assign stop_ev = lines_q.scl && lines_f.scl && !lines_q.sda && lines_f.sda;
    assign rise_ev = !lines_q.scl && lines_f.scl;
    assign fall_ev = lines_q.scl && !lines_f.scl;

    // ----------------------------------------
    // Byte decisions
    // ----------------------------------------

    // fixed top bit; straps, middle compared inverted
    assign dev_match = (shift_r[`SEBS_SA_FIXED_BIT] == `SEBS_SA_FIXED_VAL)
        && (shift_r[`SEBS_SA_SEL_HI:`SEBS_SA_SEL_LO]
            == {pins_f[3], !pins_f[2], pins_f[1]});

    // only a matching, idle device answers its address
    assign dev_accept = (state_r == SEBS_DEV) && fall_ev && byte_done_r && dev_match && !busy_r;

    // protected device refuses the first data byte
    assign wdat_refuse = (state_r == SEBS_WDAT) && fall_ev && byte_done_r
        && wp_f && first_data_r;
    assign wdat_take = (state_r == SEBS_WDAT) && fall_ev && byte_done_r && !wdat_refuse;

    // next byte after address ack in read, or after master ack
    assign rd_load = fall_ev && (((state_r == SEBS_DEV_ACK) && rw_r)
        || ((state_r == SEBS_RACK) && mack_r));
    assign rd_byte = mem_r[addr_r];

    // ----------------------------------------
    // Protocol engine
    // ----------------------------------------

    // Bit, byte and acknowledge sequencing
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_r <= SEBS_IDLE;
            bit_cnt_r <= `SEBS_BIT_FIRST;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            byte_done_r <= 1'b0;
            drive_r <= 1'b0;
            rw_r <= 1'b0;
            first_data_r <= 1'b0;
            mack_r <= 1'b0;
        end else if (stop_ev) begin
            state_r <= SEBS_IDLE;
            drive_r <= 1'b0;
        end else if (start_ev) begin
            // restart decoding, also as repeated start
            state_r <= SEBS_DEV;
            bit_cnt_r <= `SEBS_BIT_FIRST;
            byte_done_r <= 1'b0;
            drive_r <= 1'b0;
        end else begin
            unique case (state_r)
                // idle and parked states watch only for start
                SEBS_IDLE, SEBS_WAIT: begin
                    drive_r <= 1'b0;
                end
                SEBS_DEV, SEBS_WADR, SEBS_WDAT: begin
                    if (rise_ev) begin
                        shift_r <= {shift_r[6:0], lines_f.sda};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        byte_done_r <= (bit_cnt_r == `SEBS_BIT_LAST);
                    end
                    if (fall_ev && byte_done_r) begin
                        byte_done_r <= 1'b0;
                        if (state_r == SEBS_DEV) begin
                            if (dev_accept) begin
                                rw_r <= (shift_r[`SEBS_SA_RW_BIT] == `SEBS_RW_READ);
                                drive_r <= 1'b1;
                                state_r <= SEBS_DEV_ACK;
                            end else begin
                                state_r <= SEBS_WAIT;
                            end
                        end else if (state_r == SEBS_WADR) begin
                            drive_r <= 1'b1;
                            state_r <= SEBS_WADR_ACK;
                        end else if (wdat_refuse) begin
                            state_r <= SEBS_WAIT;
                        end else begin
                            drive_r <= 1'b1;
                            state_r <= SEBS_WDAT_ACK;
                        end
                    end
                end
                SEBS_DEV_ACK: begin
                    // ack held through the ninth pulse; at its fall freed in a write, first data bit driven in a read
                    if (fall_ev) begin
                        bit_cnt_r <= `SEBS_BIT_FIRST;
                        if (rw_r) begin
                            tx_r <= rd_byte;
                            drive_r <= !rd_byte[7];
                            state_r <= SEBS_RDAT;
                        end else begin
                            drive_r <= 1'b0;
                            first_data_r <= 1'b1;
                            state_r <= SEBS_WADR;
                        end
                    end
                end
                SEBS_WADR_ACK, SEBS_WDAT_ACK: begin
                    if (fall_ev) begin
                        drive_r <= 1'b0;
                        bit_cnt_r <= `SEBS_BIT_FIRST;
                        first_data_r <= (state_r == SEBS_WADR_ACK);
                        state_r <= SEBS_WDAT;
                    end
                end
                SEBS_RDAT: begin
                    // shift out eight bits, then release for the master ack
                    if (fall_ev) begin
                        if (bit_cnt_r == `SEBS_BIT_LAST) begin
                            drive_r <= 1'b0;
                            mack_r <= 1'b0;
                            state_r <= SEBS_RACK;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            drive_r <= !tx_r[6];
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                        end
                    end
                end
                SEBS_RACK: begin
                    // low at the ninth rise means more data wanted
                    if (rise_ev) begin
                        mack_r <= !lines_f.sda;
                    end
                    if (fall_ev) begin
                        bit_cnt_r <= `SEBS_BIT_FIRST;
                        if (mack_r) begin
                            tx_r <= rd_byte;
                            drive_r <= !rd_byte[7];
                            state_r <= SEBS_RDAT;
                        end else begin
                            state_r <= SEBS_WAIT;
                        end
                    end
                end
                default: begin
                    state_r <= SEBS_IDLE;
                    drive_r <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Address counter
    // ----------------------------------------

    // Word address pointer
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            addr_r <= '0;
        end else if (!stop_ev && !start_ev) begin
            if (dev_accept) begin
                // upper address bits from the slave address byte
                addr_r[ADDR_W-1:ADDR_W-3] <= shift_r[`SEBS_SA_ADR_HI:`SEBS_SA_ADR_LO];
            end else if ((state_r == SEBS_WADR) && fall_ev && byte_done_r) begin
                // low word address into the pointer
                addr_r[7:0] <= shift_r;
            end else if (wdat_take) begin
                // low bits only, wrapping inside the page
                addr_r[PAGE_W-1:0] <= addr_r[PAGE_W-1:0] + PAGE_W'(1);
            end else if (rd_load) begin
                // full counter, 2047 wraps to 0
                addr_r <= addr_r + ADDR_W'(1);
            end
        end
    end

    // ----------------------------------------
    // Page buffer
    // ----------------------------------------

    // bytes land at their page slot, later ones overwrite
    always_ff @(posedge I_CLK) begin
        if (wdat_take && !stop_ev && !start_ev) begin
            page_r[addr_r[PAGE_W-1:0]] <= shift_r;
        end
    end

    // only a write that carried data programs on its stop
    assign commit = stop_ev && dirty_r && !busy_r;

    // Slot occupancy and page origin
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            page_vld_r <= '0;
            page_base_r <= '0;
            dirty_r <= 1'b0;
        end else if (loading_r && (load_idx_r == (PAGE_W+1)'(PAGE_N))) begin
            page_vld_r <= '0;
            dirty_r <= 1'b0;
        end else if (wdat_take && !stop_ev && !start_ev) begin
            page_vld_r[addr_r[PAGE_W-1:0]] <= 1'b1;
            page_base_r <= addr_r[ADDR_W-1:PAGE_W];
            dirty_r <= 1'b1;
        end else if (start_ev && !busy_r && (state_r != SEBS_WDAT) && (state_r != SEBS_WAIT)) begin
            // A start outside SEBS_WDAT and SEBS_WAIT drops a page that never saw its stop
            page_vld_r <= '0;
            dirty_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Programming engine
    // ----------------------------------------

    // Page slots feed the FIFO in order; a full FIFO stalls the walk
    assign fifo_in.addr = {page_base_r, load_idx_r[PAGE_W-1:0]};
    assign fifo_in.data = page_r[load_idx_r[PAGE_W-1:0]];
    assign fifo_in_valid = loading_r && !load_idx_r[PAGE_W]
        && page_vld_r[load_idx_r[PAGE_W-1:0]] && !wp_f;
    // Array accepts writes only inside the busy window
    assign fifo_out_ready = busy_r;

    sebs_fifo #(.WIDTH($bits(sebs_wr_t)), .DEPTH(`SEBS_FIFO_DEPTH)) u_fifo (
        .clk(I_CLK),
        .rst(I_RESET),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            busy_r <= 1'b0;
            loading_r <= 1'b0;
            load_idx_r <= '0;
            prog_cnt_r <= '0;
        end else if (commit) begin
            busy_r <= 1'b1;
            loading_r <= 1'b1;
            load_idx_r <= '0;
            prog_cnt_r <= '0;
        end else if (busy_r) begin
            if (prog_cnt_r != PCW'(PROG_CYCLES - 1)) begin
                prog_cnt_r <= prog_cnt_r + PCW'(1);
            end
            if (loading_r) begin
                if (load_idx_r == (PAGE_W+1)'(PAGE_N)) begin
                    loading_r <= 1'b0;
                end else if (!fifo_in_valid || fifo_in_ready) begin
                    load_idx_r <= load_idx_r + (PAGE_W+1)'(1);
                end
            end else if ((prog_cnt_r == PCW'(PROG_CYCLES - 1)) && !fifo_out_valid) begin
                busy_r <= 1'b0;
            end
        end
    end

    // protected writes never reach the array
    always_ff @(posedge I_CLK) begin
        if (fifo_out_valid && fifo_out_ready && !wp_f) begin
            mem_r[fifo_out.addr] <= fifo_out.data;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // Open drain: only ever pulls low, enable active low
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_SDA <= 1'b0;
            O_SDA_OE_N <= 1'b1;
            O_BUSY <= 1'b0;
        end else begin
            O_SDA <= 1'b0;
            O_SDA_OE_N <= !drive_r;
            O_BUSY <= busy_r;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/sebs_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebs_top_checker #(
    parameter int PROG_CYCLES = 64
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Bus pins, write protect and status
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic O_SDA,
    input wire logic O_SDA_OE_N,
    input wire logic I_WRITE_PROTECT,
    input wire logic O_BUSY
);
    logic seen_r;
    logic [7:0] stop_age_r;
    int busy_cnt_r;
    // Raw start latch, stop age and busy length; raw pins lead the filter
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            seen_r <= 1'b0;
            stop_age_r <= 8'hff;
            busy_cnt_r <= 0;
        end else begin
            seen_r <= seen_r | (I_SCL & $fell(I_SDA));
            stop_age_r <= (I_SCL && $rose(I_SDA)) ? 8'h00 : stop_age_r + {7'h0, ~&stop_age_r};
            busy_cnt_r <= O_BUSY ? busy_cnt_r + 1 : 0;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    sda_low_only_a: assert property (O_SDA == 1'b0)
        else $error("data drive value not low");
    start_first_a: assert property (!O_SDA_OE_N |-> seen_r)
        else $error("data line driven before any start");
    clock_low_change_a: assert property ($changed(O_SDA_OE_N) |-> !I_SCL)
        else $error("data drive changed while clock high");
    busy_silent_a: assert property (O_BUSY |-> O_SDA_OE_N)
        else $error("data line driven while programming");
    busy_after_stop_a: assert property ($rose(O_BUSY) |-> stop_age_r <= 8'd12)
        else $error("programming started without a stop");
    busy_bound_a: assert property ($fell(O_BUSY) |-> busy_cnt_r >= PROG_CYCLES)
        else $error("programming period too short");
    busy_limit_a: assert property (O_BUSY |-> busy_cnt_r < PROG_CYCLES + 64)
        else $error("programming period too long");
    wp_blocks_a: assert property ($rose(O_BUSY) |-> !I_WRITE_PROTECT)
        else $error("programming while protected");
    busy_hold_a: assert property ($rose(O_BUSY) |=> O_BUSY [*8])
        else $error("programming period collapsed");
    drive_ends_a: assert property ($fell(O_SDA_OE_N) |-> ##[1:130] $rose(O_SDA_OE_N))
        else $error("data line held low too long");
endmodule
bind sebs_top sebs_top_checker #(.PROG_CYCLES(PROG_CYCLES)) sebs_top_checker_i (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA),
    .O_SDA_OE_N(O_SDA_OE_N), .I_WRITE_PROTECT(I_WRITE_PROTECT), .O_BUSY(O_BUSY));
`default_nettype wire

// ---- testbench/sebs_bm.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebs_bm (
    // Bus lines
    output logic scl,
    output logic sda,
    input wire logic line
);
    // Idle bus: both released high, clock stands still between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic start();
        #20 sda = 1'b1;
        #50 scl = 1'b1;
        #50 sda = 1'b0;
        #62.5 scl = 1'b0;
    endtask
    task automatic stop();
        #20 sda = 1'b0;
        #55 scl = 1'b1;
        #50 sda = 1'b1;
        #62.5;
    endtask
    // data moves only while clock low; sample late in high phase
    task automatic bit_io(input logic b, output logic r);
        #20 sda = b;
        #55 scl = 1'b1;
        #47.5 r = line;
        #2.5 scl = 1'b0;
    endtask
    // byte out MSB first, then release for the ack
    task automatic wb(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // byte in, master answers ack or nack
    task automatic rb(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule
`default_nettype wire

// ---- testbench/sebs_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebs_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0;
    int errors = 0;
    int tests_run = 0;
    wire logic scl, m_sda, oe_n, o_sda, busy;
    // Open-drain wire with pull-up
    wire logic sda = m_sda & (oe_n | o_sda);
    always #5 clk = ~clk;
    // Straps give select bits 100; long enough busy to see polls refused
    sebs_top #(.PROG_CYCLES(300)) sebs_top_i (.I_CLK(clk), .I_RESET(rst), .I_SCL(scl),
        .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE_N(oe_n), .I_SELECT_STRAP_LOW(1'b0),
        .I_SELECT_STRAP_MID_INVERTED(1'b1), .I_SELECT_STRAP_HIGH(1'b1),
        .I_WRITE_PROTECT(wp), .O_BUSY(busy));
    sebs_bm sebs_bm_i (.scl(scl), .sda(m_sda), .line(sda));
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Wrong fixed bit, straps, and middle strap not inverted
    task automatic t_miss();
        logic a;
        logic [7:0] bad [4] = '{8'h4a, 8'hda, 8'hea, 8'h8a};
        foreach (bad[k]) begin
            sebs_bm_i.start();
            sebs_bm_i.wb(bad[k], a);
            chk(8'(a), 8'h0);
            sebs_bm_i.stop();
        end
        $display("address mismatch test done");
    endtask
    // Eighteen bytes into one page, then poll until acknowledged
    task automatic t_page();
        logic a;
        int n = 0;
        sebs_bm_i.start();
        sebs_bm_i.wb(8'hca, a);
        chk(8'(a), 8'h1);
        sebs_bm_i.wb(8'ha0, a);
        chk(8'(a), 8'h1);
        for (int i = 0; i < 18; i++) begin
            sebs_bm_i.wb(8'h30 + 8'(i), a);
            chk(8'(a), 8'h1);
        end
        sebs_bm_i.stop();
        sebs_bm_i.start();
        sebs_bm_i.wb(8'hca, a);
        chk(8'(busy), 8'h1);
        chk(8'(a), 8'h0);
        while (!a && n < 20) begin
            sebs_bm_i.start();
            sebs_bm_i.wb(8'hca, a);
            n++;
        end
        sebs_bm_i.stop();
        chk({busy, 6'h0, a}, 8'h1);
        $display("page write test done");
    endtask
    // Dummy write of the word address, then read direction
    task automatic sel(input logic [7:0] wa);
        logic a;
        sebs_bm_i.start();
        sebs_bm_i.wb(8'hca, a);
        sebs_bm_i.wb(wa, a);
        sebs_bm_i.start();
        sebs_bm_i.wb(8'hcb, a);
        chk(8'(a), 8'h1);
    endtask
    // Read back the page: first two slots overwritten by the wrap
    task automatic t_read();
        logic a;
        logic [7:0] d;
        sel(8'ha0);
        for (int s = 0; s < 15; s++) begin
            sebs_bm_i.rb(d, s < 14);
            chk(d, (s < 2 ? 8'h40 : 8'h30) + 8'(s));
        end
        sebs_bm_i.stop();
        sebs_bm_i.start();
        sebs_bm_i.wb(8'hcb, a);
        sebs_bm_i.rb(d, 1'b0);
        sebs_bm_i.stop();
        chk(d, 8'h3f);
        $display("read test done");
    endtask
    // Protected write: addresses taken, data refused, nothing stored
    task automatic t_wp();
        logic a;
        logic [7:0] d;
        @(negedge clk);
        wp = 1'b1;
        sebs_bm_i.start();
        sebs_bm_i.wb(8'hca, a);
        sebs_bm_i.wb(8'ha3, a);
        chk(8'(a), 8'h1);
        sebs_bm_i.wb(8'hee, a);
        chk(8'(a), 8'h0);
        sebs_bm_i.stop();
        repeat (20) @(negedge clk);
        chk(8'(busy), 8'h0);
        wp = 1'b0;
        sel(8'ha3);
        sebs_bm_i.rb(d, 1'b0);
        sebs_bm_i.stop();
        chk(d, 8'h33);
        $display("write protect test done");
    endtask
    // Byte writes at both ends of the array, then one read across the wrap
    task automatic t_wrap();
        logic a;
        logic [7:0] d;
        for (int k = 0; k < 2; k++) begin
            sebs_bm_i.start();
            sebs_bm_i.wb(k ? 8'hc0 : 8'hce, a);
            sebs_bm_i.wb(k ? 8'h00 : 8'hff, a);
            sebs_bm_i.wb(8'h5c + 8'(k), a);
            chk(8'(a), 8'h1);
            sebs_bm_i.stop();
            repeat (400) @(negedge clk);
            chk(8'(busy), 8'h0);
        end
        sebs_bm_i.start();
        sebs_bm_i.wb(8'hce, a);
        sebs_bm_i.wb(8'hff, a);
        sebs_bm_i.start();
        sebs_bm_i.wb(8'hcf, a);
        sebs_bm_i.rb(d, 1'b1);
        chk(d, 8'h5c);
        sebs_bm_i.rb(d, 1'b0);
        sebs_bm_i.stop();
        chk(d, 8'h5d);
        $display("address wrap test done");
    endtask
    // Whole run stays far below this limit
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        conclude();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        t_miss();
        t_page();
        t_read();
        t_wp();
        t_wrap();
        conclude();
    end
endmodule
`default_nettype wire
